// file: tws_regs.vh
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// Register byte offsets
`define TWS_RX_LEVEL_OFS 8'h78
`define TWS_SDA_HOLD_OFS 8'h7c
`define TWS_ABORT_CAUSE_OFS 8'h80
`define TWS_CTRL_OFS 8'h90
`define TWS_CLEAR_ABORT_OFS 8'h94
`define TWS_CLEAR_ALL_OFS 8'h98
`define TWS_HOLD_EFF_OFS 8'h9c

// Reset values
`define TWS_SDA_HOLD_RST 32'h00000002
`define TWS_CTRL_RST 32'h00000000

// Hold register fields
`define TWS_TX_HOLD_LSB 0
`define TWS_TX_HOLD_MSB 15
`define TWS_RX_HOLD_LSB 16
`define TWS_RX_HOLD_MSB 23

// Control register fields
`define TWS_CTRL_ENABLE 0
`define TWS_CTRL_USER_ABORT 1
`define TWS_CTRL_RESTART_ALLOW 5
`define TWS_CTRL_GENCALL_START 10
`define TWS_CTRL_CMD_SEL_A 11

// Abort cause bit positions
`define TWS_AB_STARTBYTE 9
`define TWS_AB_TENBIT_RD 10
`define TWS_AB_MASTER_OFF 11
`define TWS_AB_ARB_LOST 12
`define TWS_AB_SLV_FLUSH 13
`define TWS_AB_SLV_LOST 14
`define TWS_AB_SLV_RD_PATH 15
`define TWS_AB_SW_ABORT 16
`define TWS_AB_STUCK 17
`define TWS_AB_DEVID_NOACK 18
`define TWS_AB_DEVID_ADDR 19
`define TWS_AB_DEVID_WRITE 20
`define TWS_FLUSH_LSB 23
`define TWS_FLUSH_MSB 31

// Minimum transmit hold in core clocks
`define TWS_MIN_HOLD_MASTER 16'h0001
`define TWS_MIN_HOLD_SLAVE 16'h0007

`endif

// file: tws_level_counter.v
`timescale 1ns/1ps
`include "tws_regs.vh"

module tws_level_counter #(
  parameter WIDTH = 3
) (
  // Clocking
  input wire clk_in,
  input wire rstn_in,
  input wire ce_in,
  // Events
  input wire clear_in,
  input wire push_in,
  input wire pop_in,
  // Level
  output reg [WIDTH-1:0] level_out
);

  reg [WIDTH-1:0] next_level;

  always @* begin
    next_level = level_out;
    if (clear_in) begin
      next_level = {WIDTH{1'b0}}; // RQ2
    end else if (push_in && !pop_in) begin // RQ21
      next_level = level_out + {{(WIDTH-1){1'b0}}, 1'b1}; // RQ1
    end else if (pop_in && !push_in) begin
      next_level = level_out - {{(WIDTH-1){1'b0}}, 1'b1}; // RQ1
    end
    // Push and pop together leave the level alone
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      level_out <= next_level;
    end
  end

endmodule

// file: tws_stuck_timer.v
`timescale 1ns/1ps
`include "tws_regs.vh"

module tws_stuck_timer #(
  parameter WIDTH = 32
) (
  // Clocking
  input wire clk_in,
  input wire rstn_in,
  input wire ce_in,
  // Line watch
  input wire active_in,
  input wire sda_in,
  input wire [WIDTH-1:0] limit_in,
  // Result
  output reg expired_out
);

  reg [WIDTH-1:0] count;

  // One pulse when SDA has been low for limit_in core clocks
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= {WIDTH{1'b0}};
      expired_out <= 1'b0;
    end else if (ce_in) begin
      expired_out <= 1'b0;
      if (!active_in || sda_in || limit_in == {WIDTH{1'b0}}) begin
        count <= {WIDTH{1'b0}};
      end else if (count != limit_in) begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        expired_out <= (count + {{(WIDTH-1){1'b0}}, 1'b1}) == limit_in; // RQ12
      end
    end
  end

endmodule

// file: tws_status.v
`timescale 1ns/1ps
`include "tws_regs.vh"

// Summary of operation
// RQ1: Receive level counts up per FIFO push and down per FIFO pop.
// RQ2: Receive level clears when disabled or on any transmit abort.
// RQ3: Hold register writable only while disabled; resets to two.
// RQ4: Transmit hold applies only above one cycle master, seven slave.
// RQ5: Software keeps transmit hold at most SCL low length minus two.
// RQ6: Bits 23:16 of hold register give receive hold in core clocks.
// RQ7: Reading either clear register clears all abort bits except bit 9.
// RQ8: Bit 9 clears only once its cause is gone, else re-asserts after one cycle.
// RQ9: Bits 31:23 count flushed commands; cleared when disabled.
// RQ10: Bit 20 set for device-id transfer with write commands queued.
// RQ11: Bit 19 on unacked address, bit 18 on unacked device id.
// RQ12: Bit 17 set when SDA stays low for the stuck-low limit.
// RQ13: Bit 16 set on software-requested abort through enable bit 1.
// RQ14: Bit 15 set on disallowed slave read-path transmit.
// RQ15: Slave transmitter mismatch at SCL rise sets bits 14 and 12.
// RQ16: Slave read with stale transmit data sets bit 13 and aborts.
// RQ17: Bit 12 set on master arbitration loss.
// RQ18: Bit 11 set on master start attempt with master mode off.
// RQ19: Bit 10 set on 10-bit master read with restart disabled.
// RQ20: Bit 9 set on START byte attempt with restart disabled.
// RQ21: Simultaneous push and pop leave receive level unchanged.
module tws_status #(
  parameter LEVEL_WIDTH = 3,
  parameter FLUSH_WIDTH = 9,
  parameter STUCK_WIDTH = 32,
  parameter [STUCK_WIDTH-1:0] STUCK_LIMIT = 32'h00000100
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire rstn_in,
  input wire ce_in,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // Receive FIFO strobes
  input wire rx_push_in,
  input wire rx_pop_in,
  // Controller inputs: one-cycle event pulses plus mode, line and qualifier levels
  input wire master_mode_in,
  input wire tx_fifo_flush_in,
  input wire devid_start_in,
  input wire tx_has_writes_in,
  input wire devid_addr_nack_in,
  input wire devid_nack_in,
  input wire sda_in,
  input wire scl_rise_in,
  input wire slave_tx_active_in,
  input wire slave_tx_bit_in,
  input wire slave_rd_path_in,
  input wire slave_read_req_in,
  input wire tx_fifo_nonempty_in,
  input wire arb_lost_in,
  input wire master_start_in,
  input wire master_enabled_in,
  input wire tenbit_read_in,
  input wire startbyte_req_in,
  // Status to controller
  output reg [LEVEL_WIDTH-1:0] rx_level_count_out,
  output reg controller_on_out,
  output reg transmit_abort_event_out,
  output reg [15:0] transmit_hold_cycles_out,
  output reg [7:0] receive_hold_cycles_out
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WRITE = 3'b010;
  localparam ST_RESP = 3'b100;

  reg rst_meta;
  reg rst_sync;
  reg [2:0] wstate;
  reg have_aw;
  reg have_w;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [31:0] hold_reg;
  reg [31:0] ctrl_reg;
  reg [22:0] cause;
  reg sbyte_drop;
  reg [FLUSH_WIDTH-1:0] flush_cnt;
  reg [STUCK_WIDTH-1:0] stuck_limit;
  wire [LEVEL_WIDTH-1:0] level;
  wire stuck_hit;
  wire enabled;
  wire sbyte_cause;
  wire clr_read;
  wire [22:0] new_cause;
  wire any_abort;
  wire [15:0] tx_hold;
  wire [15:0] min_hold;

  // Merge a write into a register honouring byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `TWS_RX_LEVEL_OFS) || (addr == `TWS_SDA_HOLD_OFS) ||
        (addr == `TWS_ABORT_CAUSE_OFS) || (addr == `TWS_CTRL_OFS) ||
        (addr == `TWS_CLEAR_ABORT_OFS) || (addr == `TWS_CLEAR_ALL_OFS) ||
        (addr == `TWS_HOLD_EFF_OFS) || (addr == 8'ha0);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign enabled = ctrl_reg[`TWS_CTRL_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // Receive level

  tws_level_counter #(
    .WIDTH(LEVEL_WIDTH)
  ) u_level (
    .clk_in(sys_clk_in),
    .rstn_in(rst_sync),
    .ce_in(ce_in),
    .clear_in(!enabled || any_abort), // RQ2
    .push_in(rx_push_in),
    .pop_in(rx_pop_in),
    .level_out(level)
  );

  tws_stuck_timer #(
    .WIDTH(STUCK_WIDTH)
  ) u_stuck (
    .clk_in(sys_clk_in),
    .rstn_in(rst_sync),
    .ce_in(ce_in),
    .active_in(enabled && master_mode_in),
    .sda_in(sda_in),
    .limit_in(stuck_limit),
    .expired_out(stuck_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Abort causes

  assign new_cause[8:0] = 9'h000;
  assign new_cause[`TWS_AB_STARTBYTE] = startbyte_req_in &&
    !ctrl_reg[`TWS_CTRL_RESTART_ALLOW]; // RQ20
  assign new_cause[`TWS_AB_TENBIT_RD] = master_mode_in && tenbit_read_in &&
    !ctrl_reg[`TWS_CTRL_RESTART_ALLOW]; // RQ19
  assign new_cause[`TWS_AB_MASTER_OFF] = master_start_in && !master_enabled_in; // RQ18
  assign new_cause[`TWS_AB_SLV_LOST] = slave_tx_active_in && scl_rise_in &&
    (sda_in != slave_tx_bit_in); // RQ15
  assign new_cause[`TWS_AB_ARB_LOST] = (master_mode_in && arb_lost_in) ||
    new_cause[`TWS_AB_SLV_LOST]; // RQ17 RQ15
  assign new_cause[`TWS_AB_SLV_FLUSH] = !master_mode_in && slave_read_req_in &&
    tx_fifo_nonempty_in; // RQ16
  assign new_cause[`TWS_AB_SLV_RD_PATH] = !master_mode_in && slave_rd_path_in; // RQ14
  assign new_cause[`TWS_AB_SW_ABORT] = master_mode_in &&
    ctrl_reg[`TWS_CTRL_USER_ABORT]; // RQ13
  assign new_cause[`TWS_AB_STUCK] = stuck_hit; // RQ12
  assign new_cause[`TWS_AB_DEVID_NOACK] = master_mode_in && devid_nack_in; // RQ11
  assign new_cause[`TWS_AB_DEVID_ADDR] = master_mode_in && devid_addr_nack_in; // RQ11
  assign new_cause[`TWS_AB_DEVID_WRITE] = master_mode_in && devid_start_in &&
    tx_has_writes_in; // RQ10
  assign new_cause[22:21] = 2'b00;
  assign any_abort = |new_cause;

  // The start-byte cause persists while restart is off and a start/command_sel_a target is set
  assign sbyte_cause = !ctrl_reg[`TWS_CTRL_RESTART_ALLOW] &&
    ctrl_reg[`TWS_CTRL_CMD_SEL_A] && ctrl_reg[`TWS_CTRL_GENCALL_START];

  assign clr_read = s_axi_arvalid_in && s_axi_arready_out &&
    ((s_axi_araddr_in == `TWS_CLEAR_ABORT_OFS) || (s_axi_araddr_in == `TWS_CLEAR_ALL_OFS));

  // New causes win over a clearing read in the same cycle
  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      cause <= 23'h000000;
      sbyte_drop <= 1'b0;
    end else if (ce_in) begin
      sbyte_drop <= clr_read && cause[`TWS_AB_STARTBYTE] && sbyte_cause; // RQ8
      if (clr_read) begin
        cause <= new_cause; // RQ7
      end else if (sbyte_drop && sbyte_cause) begin
        cause <= cause | new_cause | (23'h1 << `TWS_AB_STARTBYTE); // RQ8
      end else begin
        cause <= cause | new_cause;
      end
    end
  end

  // Flushed command count
  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      flush_cnt <= {FLUSH_WIDTH{1'b0}};
    end else if (ce_in) begin
      if (!enabled) begin
        flush_cnt <= {FLUSH_WIDTH{1'b0}}; // RQ9
      end else if (tx_fifo_flush_in && !(&flush_cnt)) begin
        flush_cnt <= flush_cnt + {{(FLUSH_WIDTH-1){1'b0}}, 1'b1}; // RQ9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold times

  assign tx_hold = hold_reg[`TWS_TX_HOLD_MSB:`TWS_TX_HOLD_LSB];
  assign min_hold = master_mode_in ? `TWS_MIN_HOLD_MASTER : `TWS_MIN_HOLD_SLAVE;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      wstate <= ST_IDLE;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
      hold_reg <= `TWS_SDA_HOLD_RST;
      ctrl_reg <= `TWS_CTRL_RST;
      stuck_limit <= STUCK_LIMIT;
    end else if (ce_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      case (wstate)
        ST_IDLE: begin
          if (s_axi_awvalid_in && !have_aw && !s_axi_awready_out) begin
            s_axi_awready_out <= 1'b1;
          end
          if (s_axi_wvalid_in && !have_w && !s_axi_wready_out) begin
            s_axi_wready_out <= 1'b1;
          end
          if (s_axi_awvalid_in && s_axi_awready_out) begin
            have_aw <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
          end
          if (s_axi_wvalid_in && s_axi_wready_out) begin
            have_w <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
          end
          if ((have_aw || s_axi_awready_out) && (have_w || s_axi_wready_out)) begin
            wstate <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          have_aw <= 1'b0;
          have_w <= 1'b0;
          s_axi_bvalid_out <= 1'b1;
          s_axi_bresp_out <= mapped(aw_addr) ? 2'b00 : 2'b11;
          if (aw_addr == `TWS_SDA_HOLD_OFS && !enabled) begin
            hold_reg <= merge(hold_reg, w_data, w_strb) & 32'h00ffffff; // RQ3
          end
          if (aw_addr == `TWS_CTRL_OFS) begin
            ctrl_reg <= merge(ctrl_reg, w_data, w_strb) & 32'h00000c23;
          end
          if (aw_addr == 8'ha0) begin
            stuck_limit <= merge(stuck_limit, w_data, w_strb);
          end
          wstate <= ST_RESP;
        end
        ST_RESP: begin
          if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            wstate <= ST_IDLE;
          end
        end
        default: begin
          wstate <= ST_IDLE;
        end
      endcase
      // Abort request is self-clearing once seen
      if (wstate != ST_WRITE && ctrl_reg[`TWS_CTRL_USER_ABORT] && master_mode_in) begin
        ctrl_reg[`TWS_CTRL_USER_ABORT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= 2'b00;
    end else if (ce_in) begin
      s_axi_arready_out <= 1'b0;
      if (s_axi_rvalid_out) begin
        if (s_axi_rready_in) begin
          s_axi_rvalid_out <= 1'b0;
        end
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= mapped(s_axi_araddr_in) ? 2'b00 : 2'b11;
        case (s_axi_araddr_in)
          `TWS_RX_LEVEL_OFS: s_axi_rdata_out <= {{(32-LEVEL_WIDTH){1'b0}}, level}; // RQ1
          `TWS_SDA_HOLD_OFS: s_axi_rdata_out <= hold_reg;
          `TWS_ABORT_CAUSE_OFS: s_axi_rdata_out <= {flush_cnt, cause};
          `TWS_CTRL_OFS: s_axi_rdata_out <= ctrl_reg;
          `TWS_HOLD_EFF_OFS: s_axi_rdata_out <= {8'h00, receive_hold_cycles_out,
            transmit_hold_cycles_out};
          8'ha0: s_axi_rdata_out <= stuck_limit;
          default: s_axi_rdata_out <= 32'h00000000;
        endcase
      end else if (s_axi_arvalid_in) begin
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs to the controller

  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      rx_level_count_out <= {LEVEL_WIDTH{1'b0}};
      controller_on_out <= 1'b0;
      transmit_abort_event_out <= 1'b0;
      transmit_hold_cycles_out <= 16'h0000;
      receive_hold_cycles_out <= 8'h00;
    end else if (ce_in) begin
      rx_level_count_out <= level;
      controller_on_out <= enabled;
      transmit_abort_event_out <= any_abort; // RQ16
      // Below the mode minimum the minimum hold itself applies
      transmit_hold_cycles_out <= (tx_hold > min_hold) ? tx_hold : min_hold; // RQ4
      receive_hold_cycles_out <= hold_reg[`TWS_RX_HOLD_MSB:`TWS_RX_HOLD_LSB]; // RQ6
    end
  end

endmodule

// file: tws_status_properties.sv
`timescale 1ns/1ps
module tws_status_chk #(
  parameter LEVEL_WIDTH = 3
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire rstn_in,
  // Register bus
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire s_axi_rvalid_out,
  // Controller side
  input wire rx_push_in,
  input wire rx_pop_in,
  input wire master_mode_in,
  input wire arb_lost_in,
  input wire [LEVEL_WIDTH-1:0] rx_level_count_out,
  input wire controller_on_out,
  input wire transmit_abort_event_out,
  input wire [15:0] transmit_hold_cycles_out,
  input wire [7:0] receive_hold_cycles_out
);
  // Outputs stay zero for a few edges after reset while the synchroniser drains
  reg [2:0] up_cnt;
  wire live = up_cnt == 3'h7;
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      up_cnt <= 3'h0;
    end else if (!live) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_push;
    rx_push_in && !rx_pop_in && controller_on_out && !transmit_abort_event_out ##1
    controller_on_out && !transmit_abort_event_out && ~&rx_level_count_out;
  endsequence
  sequence s_pop;
    rx_pop_in && !rx_push_in && controller_on_out && !transmit_abort_event_out ##1
    controller_on_out && !transmit_abort_event_out && |rx_level_count_out;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  property p_level_up;
    s_push |=> rx_level_count_out == $past(rx_level_count_out) + 1'b1;
  endproperty
  property p_level_down;
    s_pop |=> rx_level_count_out == $past(rx_level_count_out) - 1'b1;
  endproperty
  property p_off_zero;
    !controller_on_out [*3] |-> rx_level_count_out == '0;
  endproperty
  property p_abort_zero;
    transmit_abort_event_out && !rx_push_in ##1 !rx_push_in |-> ##2 rx_level_count_out == '0;
  endproperty
  property p_abort_event;
    arb_lost_in && master_mode_in && controller_on_out |=> transmit_abort_event_out;
  endproperty
  property p_tx_hold_min;
    live && $stable(master_mode_in) && $past(master_mode_in, 2) == master_mode_in |->
      transmit_hold_cycles_out >= (master_mode_in ? 16'h0001 : 16'h0007);
  endproperty
  property p_rx_hold_frozen;
    live && controller_on_out && $past(controller_on_out) |-> $stable(receive_hold_cycles_out);
  endproperty
  property p_aw_ready;
    !s_axi_awvalid_in ##1 s_axi_awvalid_in |=> s_axi_awready_out;
  endproperty
  property p_b_delay;
    s_wr_taken |-> ##2 s_axi_bvalid_out;
  endproperty
  property p_r_after_ar;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_level_up: assert property (p_level_up) else $error("level missed a push");
  a_level_down: assert property (p_level_down) else $error("level missed a pop");
  a_off_zero: assert property (p_off_zero) else $error("level nonzero while off");
  a_abort_zero: assert property (p_abort_zero) else $error("level kept on abort");
  a_abort_event: assert property (p_abort_event) else $error("no abort pulse");
  a_tx_hold_min: assert property (p_tx_hold_min) else $error("tx hold below floor");
  a_rx_hold_frozen: assert property (p_rx_hold_frozen) else $error("hold moved");
  a_aw_ready: assert property (p_aw_ready) else $error("awready late");
  a_b_delay: assert property (p_b_delay) else $error("bvalid late");
  a_r_after_ar: assert property (p_r_after_ar) else $error("rvalid late");
endmodule

// file: tws_bus_model.sv
`timescale 1ns/1ps
module tws_bus_model (
  // Clock
  input wire clk_in,
  // Frame request
  input wire go_in,
  input wire [7:0] low_len_in,
  // Bus view
  output reg sda_out,
  output reg scl_rise_out
);
  reg [7:0] cnt;
  initial begin
    cnt = 8'h00;
    sda_out = 1'b1;
    scl_rise_out = 1'b0;
  end
  // Pull-up holds SDA high between frames; SCL only rises inside a frame
  always @(posedge clk_in) begin
    scl_rise_out <= cnt == 8'h02;
    sda_out <= !(go_in || cnt > 8'h01);
    if (go_in) begin
      cnt <= low_len_in;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] CTL = 32'h00000c01;
  logic clk = 1'b0, rstn = 1'b0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, mm = 0, sta = 0, go = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00, len = 8'h00, rxh;
  logic [31:0] wd = 32'h0, rdat, rd;
  logic [3:0] strb = 4'h0;
  logic qual = 1'b1;
  logic [11:0] ev = 12'h000;
  logic awr, wr_r, bv, arr, rv, sda, sclr, on, abev;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] lvl;
  logic [15:0] txh;
  int n_mismatch = 0, num_checks = 0;
  int bitv[9] = '{20, 19, 18, 12, 11, 10, 9, 15, 13};
  always #10 clk = ~clk;
  tws_status #(.STUCK_LIMIT(32'h00000008)) tws_status_i (
    .sys_clk_in(clk), .rstn_in(rstn), .ce_in(1'b1),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
    .rx_push_in(ev[10]), .rx_pop_in(ev[11]), .master_mode_in(mm), .tx_fifo_flush_in(ev[9]),
    .devid_start_in(ev[0]), .tx_has_writes_in(qual), .devid_addr_nack_in(ev[1]),
    .devid_nack_in(ev[2]), .sda_in(sda), .scl_rise_in(sclr), .slave_tx_active_in(sta),
    .slave_tx_bit_in(sta), .slave_rd_path_in(ev[7]), .slave_read_req_in(ev[8]),
    .tx_fifo_nonempty_in(qual), .arb_lost_in(ev[3]), .master_start_in(ev[4]),
    .master_enabled_in(!qual), .tenbit_read_in(ev[5]), .startbyte_req_in(ev[6]),
    .rx_level_count_out(lvl), .controller_on_out(on), .transmit_abort_event_out(abev),
    .transmit_hold_cycles_out(txh), .receive_hold_cycles_out(rxh));
  tws_bus_model tws_bus_model_i (.clk_in(clk), .go_in(go), .low_len_in(len),
    .sda_out(sda), .scl_rise_out(sclr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awa <= a; wd <= d; strb <= 4'hf; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (br && bv) begin
        r = bresp;
        br <= 1'b0;
      end
    end while (awv || wv || br);
  endtask
  task automatic rdv(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rr && rv) begin
        d = rdat;
        r = rresp;
        rr <= 1'b0;
      end
    end while (arv || rr);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rdv(a, rd, rs);
    chk(rd, exp);
  endtask
  task automatic pulse(input logic [11:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 12'h000;
  endtask
  // Holds SDA low for n cycles with one SCL rise near the end
  task automatic frame(input logic [7:0] n);
    @(posedge clk);
    len <= n; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (n + 4) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(8'h7c, 32'h00000002);
    wr(8'h78, 32'h000000ff, rs);
    rdc(8'h78, 32'h0);
    rdc(8'h80, 32'h0);
    rdv(8'h40, rd, rs);
    chk({30'h0, rs}, 32'h3);
    wr(8'h40, 32'h1, rs);
    chk({30'h0, rs}, 32'h3);
    wr(8'ha0, 32'h00000008, rs);
    wr(8'h7c, 32'h00050009, rs);
    rdc(8'h7c, 32'h00050009);
    mm <= 1'b1;
    repeat (3) @(posedge clk);
    chk({24'h0, rxh}, 32'h5);
    chk({16'h0, txh}, 32'h9);
    wr(8'h7c, 32'h00000003, rs);
    repeat (3) @(posedge clk);
    chk({16'h0, txh}, 32'h3);
    mm <= 1'b0;
    repeat (3) @(posedge clk);
    chk({16'h0, txh}, 32'h7);
    wr(8'h90, CTL, rs);
    wr(8'h7c, 32'h00ff0020, rs);
    rdc(8'h7c, 32'h00000003);
    repeat (3) pulse(12'h400);
    rdc(8'h78, 32'h3);
    pulse(12'hc00);
    rdc(8'h78, 32'h3);
    chk({29'h0, lvl}, 32'h3);
    pulse(12'h800);
    rdc(8'h78, 32'h2);
    for (int i = 0; i < 9; i++) begin
      mm <= i < 7;
      pulse(12'h001 << i);
      if (i == 6) pulse(12'h008);
      rdc(8'h80, (32'h1 << bitv[i]) | (i == 6 ? 32'h1000 : 32'h0));
      rdc(8'h78, 32'h0);
      rdc(i[0] ? 8'h98 : 8'h94, 32'h0);
      rdc(8'h80, i == 6 ? 32'h00000200 : 32'h0);
      if (i == 6) begin
        wr(8'h90, CTL | 32'h20, rs);
        rdc(8'h98, 32'h0);
        rdc(8'h80, 32'h0);
        wr(8'h90, CTL, rs);
      end
    end
    mm <= 1'b1;
    wr(8'h90, CTL | 32'h2, rs);
    rdc(8'h80, 32'h00010000);
    rdc(8'h94, 32'h0);
    frame(8'd20);
    rdc(8'h80, 32'h00020000);
    rdc(8'h94, 32'h0);
    mm <= 1'b0;
    sta <= 1'b1;
    frame(8'd4);
    rdc(8'h80, 32'h00005000);
    sta <= 1'b0;
    rdc(8'h98, 32'h0);
    qual <= 1'b0;
    mm <= 1'b1;
    pulse(12'h011);
    mm <= 1'b0;
    pulse(12'h100);
    qual <= 1'b1;
    rdc(8'h80, 32'h0);
    repeat (3) pulse(12'h200);
    rdc(8'h80, 32'h3 << 23);
    pulse(12'h400);
    wr(8'h90, 32'h0, rs);
    rdc(8'h80, 32'h0);
    rdc(8'h78, 32'h0);
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
endmodule
bind tws_status tws_status_chk #(.LEVEL_WIDTH(LEVEL_WIDTH)) tws_status_chk_i (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .rx_push_in(rx_push_in), .rx_pop_in(rx_pop_in), .master_mode_in(master_mode_in),
  .arb_lost_in(arb_lost_in), .rx_level_count_out(rx_level_count_out),
  .controller_on_out(controller_on_out), .transmit_abort_event_out(transmit_abort_event_out),
  .transmit_hold_cycles_out(transmit_hold_cycles_out),
  .receive_hold_cycles_out(receive_hold_cycles_out));
